// ===== hdl/cbsw_core.sv
// Configuration sequencer: dual boot, identity, locks, reload and wake-up
// Assumes loaders and ports outside; pins and wake clock are asynchronous
//
// Overview of operation
// - Internal golden: flash first, then internal image
// - External golden: internal first, then flash image
// - 64-bit die ID, fixed low 56 bits
// - Top eight ID bits from feature row, default zero
// - Custom ID enable replaces returned identity code
// - Readback lock refuses readback and programming, other functions work
// - Locked overflowing image also blocks sector readback
// - Lock blocks programming until erase clears it
// - Nonvolatile OTP rejects erase/program, allows self boot
// - Full OTP also blocks JTAG SRAM writes
// - Reload trigger without background: full warm reboot
// - Background reload: configuration step only, stay user
// - Load done sets done flag, starts wake-up
// - Output enable low keeps outputs off
// - Core reset low during configuration except background reload, released in wake
// - Write disable low until wake-up
// - DONE high only after error-free configuration
// - Four wake transitions on the selected clock
// - Start primitive: wake clock from external pin
`timescale 1ns/1ps
module cbsw_core
  import cbsw_pkg::*;
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        power_up_i,
  input  wire logic                        golden_image_location_i,
  input  wire logic [cbsw_pkg::DIE_FIXED_W-1:0] die_fixed_i,
  input  wire logic [cbsw_pkg::DIE_USER_W-1:0]  die_user_i,
  input  wire logic                        custom_id_enable_i,
  input  wire logic [cbsw_pkg::IDCODE_W-1:0]    custom_identity_value_i,
  input  wire logic [cbsw_pkg::IDCODE_W-1:0]    builtin_idcode_i,
  input  wire logic                        readback_lock_i,
  input  wire logic                        image_in_user_sector_i,
  input  wire logic [1:0]                  otp_lock_select_i,
  input  wire logic                        background_reload_i,
  input  wire logic                        reload_request_n_i,
  input  wire logic                        reload_command_i,
  input  wire logic                        readback_req_i,
  input  wire logic                        sector_readback_req_i,
  input  wire logic                        program_req_i,
  input  wire logic                        erase_req_i,
  input  wire logic                        erase_done_i,
  input  wire logic                        jtag_sram_write_req_i,
  input  wire logic                        load_done_i,
  input  wire logic                        load_error_i,
  input  wire logic                        jtag_config_i,
  input  wire logic                        start_prim_used_i,
  input  wire logic                        config_clock_i,
  input  wire logic                        jtag_tck_i,
  input  wire logic                        wake_clock_input_i,
  output logic                             load_start_o,
  output logic [1:0]                       load_source_o,
  output logic [cbsw_pkg::DIE_ID_W-1:0]    unique_die_id_o,
  output logic [cbsw_pkg::IDCODE_W-1:0]    idcode_o,
  output logic                             readback_allow_o,
  output logic                             sector_readback_allow_o,
  output logic                             program_allow_o,
  output logic                             erase_allow_o,
  output logic                             jtag_sram_write_allow_o,
  output logic                             internal_done_o,
  output logic                             global_output_enable_o,
  output logic                             global_core_reset_o,
  output logic                             global_write_disable_o,
  output logic                             done_o,
  output logic                             user_mode_o
);

  cbsw_state_t state_q, state_d;
  logic [1:0]  wcnt_q;
  logic        lock_q;
  logic        idone_q;
  logic        err_q;
  logic        start_q;
  logic [1:0]  src_q;
  logic [DIE_USER_W-1:0] user_id_q;
  logic [2:0]  rq_sync_q;
  logic [2:0]  ck_sync_q;
  logic [2:0]  cfg_sync_q;
  logic [2:0]  tck_sync_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rq_sync_q  <= 3'h7;
      ck_sync_q  <= 3'h0;
      cfg_sync_q <= 3'h0;
      tck_sync_q <= 3'h0;
    end else begin
      rq_sync_q  <= {rq_sync_q[1:0], reload_request_n_i};
      ck_sync_q  <= {ck_sync_q[1:0], wake_clock_input_i};
      cfg_sync_q <= {cfg_sync_q[1:0], config_clock_i};
      tck_sync_q <= {tck_sync_q[1:0], jtag_tck_i};
    end
  end

  wire rq_fall   = rq_sync_q[2] & ~rq_sync_q[1];
  wire ck_rise   = ~ck_sync_q[2] & ck_sync_q[1];
  wire cfg_rise  = ~cfg_sync_q[2] & cfg_sync_q[1];
  wire tck_rise  = ~tck_sync_q[2] & tck_sync_q[1];
  // Wake step clock: start pin, else JTAG or config clock
  wire wake_tick = start_prim_used_i ? ck_rise :
                   (jtag_config_i ? tck_rise : cfg_rise);
  wire reload    = rq_fall | reload_command_i;

  // ----------------------------------------------------------------------
  // Identity
  // ----------------------------------------------------------------------
  assign unique_die_id_o = {user_id_q, die_fixed_i};
  assign idcode_o = custom_id_enable_i ? custom_identity_value_i
                                       : builtin_idcode_i;

  // ----------------------------------------------------------------------
  // Security gating
  // ----------------------------------------------------------------------
  wire otp_nv   = (otp_lock_select_i == OTP_NV) || (otp_lock_select_i == OTP_NV_SRAM);
  assign readback_allow_o = readback_req_i & ~lock_q;
  assign sector_readback_allow_o = sector_readback_req_i &
                                   ~(lock_q & image_in_user_sector_i);
  assign program_allow_o  = program_req_i & ~lock_q & ~otp_nv;
  assign erase_allow_o    = erase_req_i & ~otp_nv;
  assign jtag_sram_write_allow_o = jtag_sram_write_req_i &
                                   (otp_lock_select_i != OTP_NV_SRAM);

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  wire [1:0] first_src  = golden_image_location_i ? SRC_NVM : SRC_FLASH;
  wire [1:0] golden_src = golden_image_location_i ? SRC_FLASH : SRC_NVM;

  always_comb begin
    state_d = state_q;
    case (state_q)
      CBSW_IDLE: begin
        if (power_up_i) begin
          state_d = CBSW_INIT;
        end
      end
      CBSW_INIT: begin
        state_d = CBSW_LOAD_FIRST;
      end
      CBSW_LOAD_FIRST: begin
        if (load_error_i) begin
          state_d = CBSW_LOAD_GOLDEN;
        end else if (load_done_i) begin
          state_d = CBSW_WAKE;
        end
      end
      CBSW_LOAD_GOLDEN: begin
        if (load_error_i) begin
          state_d = CBSW_FAIL;
        end else if (load_done_i) begin
          state_d = CBSW_WAKE;
        end
      end
      CBSW_WAKE: begin
        if (wake_tick && wcnt_q == WAKE_CNT_LAST) begin
          state_d = CBSW_USER;
        end
      end
      CBSW_USER: begin
        if (reload) begin
          state_d = background_reload_i ? CBSW_BG_LOAD : CBSW_INIT;
        end
      end
      CBSW_BG_LOAD: begin
        if (load_done_i || load_error_i) begin
          state_d = CBSW_USER;
        end
      end
      CBSW_FAIL: begin
        if (reload) begin
          state_d = CBSW_INIT;
        end
      end
      default: begin
        state_d = CBSW_IDLE;
      end
    endcase
  end

  wire enter_load = (state_d == CBSW_LOAD_FIRST && state_q != CBSW_LOAD_FIRST) ||
                    (state_d == CBSW_LOAD_GOLDEN && state_q != CBSW_LOAD_GOLDEN) ||
                    (state_d == CBSW_BG_LOAD && state_q != CBSW_BG_LOAD);

  // ----------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= CBSW_IDLE;
      wcnt_q    <= WAKE_CNT_RST;
      idone_q   <= 1'b0;
      err_q     <= 1'b0;
      start_q   <= 1'b0;
      src_q     <= SRC_NONE;
      user_id_q <= DIE_USER_RST;
    end else begin
      state_q <= state_d;
      start_q <= enter_load;
      if (state_q == CBSW_INIT) begin
        user_id_q <= die_user_i;
        idone_q   <= 1'b0;
        err_q     <= 1'b0;
        wcnt_q    <= WAKE_CNT_RST;
      end
      if (state_d == CBSW_LOAD_FIRST || state_d == CBSW_BG_LOAD) begin
        src_q <= first_src;
      end else if (state_d == CBSW_LOAD_GOLDEN) begin
        src_q <= golden_src;
      end
      if (state_q == CBSW_WAKE && state_d == CBSW_WAKE && load_error_i) begin
        err_q <= 1'b1;
      end
      if (state_q == CBSW_LOAD_GOLDEN && load_error_i) begin
        err_q <= 1'b1;
      end
      if (state_d == CBSW_WAKE && state_q != CBSW_WAKE) begin
        idone_q <= 1'b1;
      end
      if (state_q == CBSW_WAKE && wake_tick) begin
        wcnt_q <= wcnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Readback lock fuse, cleared only by reset or erase
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (erase_done_i && erase_allow_o) begin
      lock_q <= 1'b0;
    end else if (readback_lock_i) begin
      lock_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Wake-up outputs, order: GLOBAL_WRITE_DISABLE, GLOBAL_CORE_RESET, GLOBAL_OUTPUT_ENABLE, DONE
  // ----------------------------------------------------------------------
  logic goe_q, gsr_q, gwd_q, done_q;
  wire step = (state_q == CBSW_WAKE) & wake_tick;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      goe_q  <= 1'b0;
      gsr_q  <= 1'b0;
      gwd_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (state_q == CBSW_INIT) begin
      goe_q  <= 1'b0;
      gsr_q  <= 1'b0;
      gwd_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (step) begin
      case (wcnt_q)
        2'h0:    gwd_q  <= 1'b1;
        2'h1:    gsr_q  <= 1'b1;
        2'h2:    goe_q  <= 1'b1;
        default: done_q <= ~err_q;
      endcase
    end
  end

  assign global_output_enable_o = goe_q;
  assign global_core_reset_o    = gsr_q;
  assign global_write_disable_o = gwd_q;
  assign done_o                 = done_q;
  assign internal_done_o        = idone_q;
  assign load_start_o           = start_q;
  assign load_source_o          = src_q;
  assign user_mode_o            = (state_q == CBSW_USER) | (state_q == CBSW_BG_LOAD);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_RB_BLOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    lock_q |-> !readback_allow_o) else $error("readback while locked");
  AST_PROG_BLOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (lock_q || otp_nv) |-> !program_allow_o) else $error("program while locked");
  AST_JTAG_SRAM: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (otp_lock_select_i == OTP_NV_SRAM) |-> !jtag_sram_write_allow_o)
    else $error("jtag sram write under otp");
  AST_GOE_ORDER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(goe_q) |-> gsr_q && gwd_q) else $error("goe before gsr");
  AST_DONE_LAST: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(done_q) |-> goe_q && !err_q) else $error("done out of order");
  AST_GSR_CFG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_q == CBSW_LOAD_FIRST && !background_reload_i) |-> !gsr_q)
    else $error("core reset released in config");
  AST_BG_USER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_q == CBSW_USER && reload && background_reload_i) |=> user_mode_o && goe_q)
    else $error("background reload disrupted");
  AST_GOLDEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_q == CBSW_LOAD_FIRST && load_error_i) |=> src_q == golden_src)
    else $error("golden source wrong");
  AST_IDCODE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    custom_id_enable_i |-> idcode_o == custom_identity_value_i)
    else $error("custom id not returned");

endmodule : cbsw_core

// ===== hdl/cbsw_pkg.sv
// Constants and types for the configuration boot, security and wake-up block
// Assumes a single 100 MHz reference clock domain
package cbsw_pkg;

  // ----------------------------------------------------------------------
  // Widths and wake step count
  // ----------------------------------------------------------------------
  localparam int unsigned DIE_ID_W     = 64;
  localparam int unsigned DIE_FIXED_W  = 56;
  localparam int unsigned DIE_USER_W   = 8;
  localparam int unsigned IDCODE_W     = 32;
  localparam int unsigned WAKE_STEPS   = 4;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [DIE_USER_W-1:0] DIE_USER_RST = 8'h00;
  localparam logic [1:0] OTP_OFF         = 2'h0;
  localparam logic [1:0] OTP_NV          = 2'h1;
  localparam logic [1:0] OTP_NV_SRAM     = 2'h2;
  localparam logic [1:0] SRC_NONE        = 2'h0;
  localparam logic [1:0] SRC_FLASH       = 2'h1;
  localparam logic [1:0] SRC_NVM         = 2'h2;
  localparam logic [1:0] WAKE_CNT_RST    = 2'h0;
  localparam logic [1:0] WAKE_CNT_LAST   = 2'h3;

  typedef enum logic [3:0] {
    CBSW_IDLE,
    CBSW_INIT,
    CBSW_LOAD_FIRST,
    CBSW_LOAD_GOLDEN,
    CBSW_WAKE,
    CBSW_USER,
    CBSW_BG_LOAD,
    CBSW_FAIL
  } cbsw_state_t;

endpackage : cbsw_pkg

// ===== test/cbsw_core_bench.sv
// Self-checking bench for the configuration sequencer
// Assumes the loader model answers load requests and supplies the link clock
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module cbsw_core_bench;
  import cbsw_pkg::*;
  logic ref_clk_i, rst_i, power_up_i, golden_image_location_i, custom_id_enable_i;
  logic [DIE_FIXED_W-1:0] die_fixed_i;
  logic [DIE_USER_W-1:0]  die_user_i;
  logic [IDCODE_W-1:0]    custom_identity_value_i, builtin_idcode_i, idcode_o;
  logic [DIE_ID_W-1:0]    unique_die_id_o;
  logic [1:0]             otp_lock_select_i, load_source_o;
  logic readback_lock_i, image_in_user_sector_i, background_reload_i, reload_command_i;
  logic reload_request_n_i, readback_req_i, sector_readback_req_i, program_req_i;
  logic erase_req_i, erase_done_i, jtag_sram_write_req_i, load_done_i, load_error_i;
  logic jtag_config_i, start_prim_used_i, load_start_o, readback_allow_o;
  logic sector_readback_allow_o, program_allow_o, erase_allow_o, jtag_sram_write_allow_o;
  logic internal_done_o, global_output_enable_o, global_core_reset_o;
  logic global_write_disable_o, done_o, user_mode_o, link_clk, fail_flash, fail_nvm;
  logic bad_order;
  wire  config_clock_i, jtag_tck_i, wake_clock_input_i;
  logic [1:0] srcs[$];
  int   error_cnt, compares, cycles;
  // Only the selected wake clock toggles, so a wrong selection stalls wake-up
  assign config_clock_i     = link_clk & ~jtag_config_i & ~start_prim_used_i;
  assign jtag_tck_i         = link_clk & jtag_config_i & ~start_prim_used_i;
  assign wake_clock_input_i = link_clk & start_prim_used_i;
  cbsw_core dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .power_up_i(power_up_i),
    .golden_image_location_i(golden_image_location_i), .die_fixed_i(die_fixed_i),
    .die_user_i(die_user_i), .custom_id_enable_i(custom_id_enable_i),
    .custom_identity_value_i(custom_identity_value_i), .builtin_idcode_i(builtin_idcode_i),
    .readback_lock_i(readback_lock_i), .image_in_user_sector_i(image_in_user_sector_i),
    .otp_lock_select_i(otp_lock_select_i), .background_reload_i(background_reload_i),
    .reload_request_n_i(reload_request_n_i), .reload_command_i(reload_command_i),
    .readback_req_i(readback_req_i), .sector_readback_req_i(sector_readback_req_i),
    .program_req_i(program_req_i), .erase_req_i(erase_req_i), .erase_done_i(erase_done_i),
    .jtag_sram_write_req_i(jtag_sram_write_req_i), .load_done_i(load_done_i),
    .load_error_i(load_error_i), .jtag_config_i(jtag_config_i),
    .start_prim_used_i(start_prim_used_i), .config_clock_i(config_clock_i),
    .jtag_tck_i(jtag_tck_i), .wake_clock_input_i(wake_clock_input_i),
    .load_start_o(load_start_o), .load_source_o(load_source_o),
    .unique_die_id_o(unique_die_id_o), .idcode_o(idcode_o),
    .readback_allow_o(readback_allow_o), .sector_readback_allow_o(sector_readback_allow_o),
    .program_allow_o(program_allow_o), .erase_allow_o(erase_allow_o),
    .jtag_sram_write_allow_o(jtag_sram_write_allow_o), .internal_done_o(internal_done_o),
    .global_output_enable_o(global_output_enable_o),
    .global_core_reset_o(global_core_reset_o),
    .global_write_disable_o(global_write_disable_o), .done_o(done_o),
    .user_mode_o(user_mode_o));
  cbsw_loader_model model_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .load_start_i(load_start_o),
    .load_source_i(load_source_o), .fail_flash_i(fail_flash), .fail_nvm_i(fail_nvm),
    .load_done_o(load_done_i), .load_error_o(load_error_i), .link_clk_o(link_clk));
  // ----------------------------------------------------------------------
  // Clock, timeout, load log and release-order monitor
  // ----------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (load_start_o === 1'b1) srcs.push_back(load_source_o);
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  always @(negedge ref_clk_i) begin
    if (!rst_i && ((done_o && !global_output_enable_o) ||
        (global_output_enable_o && !global_core_reset_o) ||
        (global_core_reset_o && !global_write_disable_o))) bad_order = 1'b1;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step
  task automatic wait_user();
    for (int i = 0; i < 3000 && user_mode_o !== 1'b1; i++) step(1);
  endtask : wait_user
  task automatic wait_srcs(input int n);
    for (int i = 0; i < 3000 && srcs.size() < n; i++) step(1);
  endtask : wait_srcs
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_i = 1'b1; power_up_i = 1'b0; golden_image_location_i = 1'b0;
    die_fixed_i = 56'hA5_1234_5678_9ABC; die_user_i = 8'h3C; custom_id_enable_i = 1'b0;
    custom_identity_value_i = 32'hC0DE_0001; builtin_idcode_i = 32'h0000_1111; // Arbitrary
    readback_lock_i = 1'b0; image_in_user_sector_i = 1'b1; otp_lock_select_i = OTP_OFF;
    background_reload_i = 1'b0; reload_request_n_i = 1'b1; reload_command_i = 1'b0;
    readback_req_i = 1'b1; sector_readback_req_i = 1'b1; program_req_i = 1'b1;
    erase_req_i = 1'b1; jtag_sram_write_req_i = 1'b1; erase_done_i = 1'b0;
    jtag_config_i = 1'b0; start_prim_used_i = 1'b0; fail_flash = 1'b1; fail_nvm = 1'b0;
    error_cnt = 0; compares = 0; cycles = 0; bad_order = 1'b0;
    step(16);
    rst_i = 1'b0;
    `CHK(unique_die_id_o[63:56], DIE_USER_RST)
    power_up_i = 1'b1;
    step(1);
    power_up_i = 1'b0;
    wait_user();
    `CHK(srcs.size(), 2)
    `CHK(srcs[0], SRC_FLASH)
    `CHK(srcs[1], SRC_NVM)
    `CHK(internal_done_o, 1'b1)
    `CHK({global_write_disable_o, global_core_reset_o, global_output_enable_o}, 3'h7)
    `CHK(done_o, 1'b1)
    `CHK(unique_die_id_o, {8'h3C, die_fixed_i})
    `CHK(idcode_o, builtin_idcode_i)
    custom_id_enable_i = 1'b1;
    step(1);
    `CHK(idcode_o, custom_identity_value_i)
    $display("Test boot and identity finished");
    readback_lock_i = 1'b1;
    step(2);
    `CHK(readback_allow_o, 1'b0)
    `CHK(jtag_sram_write_allow_o, 1'b1)
    `CHK(sector_readback_allow_o, 1'b0)
    `CHK(program_allow_o, 1'b0)
    image_in_user_sector_i = 1'b0;
    step(1);
    `CHK(sector_readback_allow_o, 1'b1)
    readback_lock_i = 1'b0;
    erase_done_i = 1'b1;
    step(1);
    erase_done_i = 1'b0;
    step(1);
    `CHK({readback_allow_o, program_allow_o}, 2'h3)
    otp_lock_select_i = OTP_NV;
    step(1);
    `CHK({erase_allow_o, program_allow_o, jtag_sram_write_allow_o}, 3'h1)
    otp_lock_select_i = OTP_NV_SRAM;
    step(1);
    `CHK({erase_allow_o, program_allow_o, jtag_sram_write_allow_o}, 3'h0)
    $display("Test locks finished");
    background_reload_i = 1'b1;
    reload_command_i = 1'b1;
    step(1);
    reload_command_i = 1'b0;
    wait_srcs(3);
    `CHK({user_mode_o, global_core_reset_o}, 2'h3)
    step(40);
    `CHK({srcs.size(), user_mode_o, done_o}, {32'd3, 2'h3})
    $display("Test background reload finished");
    background_reload_i = 1'b0;
    golden_image_location_i = 1'b1;
    start_prim_used_i = 1'b1;
    jtag_config_i = 1'b1;
    fail_nvm = 1'b1;
    fail_flash = 1'b0;
    reload_request_n_i = 1'b0;
    step(4);
    reload_request_n_i = 1'b1;
    wait_srcs(4);
    `CHK({global_output_enable_o, global_core_reset_o, global_write_disable_o}, 3'h0)
    `CHK({user_mode_o, done_o}, 2'h0)
    wait_user();
    `CHK(srcs[3], SRC_NVM)
    `CHK(srcs[4], SRC_FLASH)
    `CHK({done_o, global_output_enable_o}, 2'h3)
    $display("Test warm reload finished");
    fail_flash = 1'b1;
    reload_command_i = 1'b1;
    step(1);
    reload_command_i = 1'b0;
    wait_srcs(7);
    step(40);
    `CHK({done_o, user_mode_o}, 2'h0)
    $display("Test failed reload finished");
    fail_flash = 1'b0;
    start_prim_used_i = 1'b0;
    reload_command_i = 1'b1;
    step(1);
    reload_command_i = 1'b0;
    wait_user();
    `CHK(srcs.size(), 9)
    `CHK(srcs[7], SRC_NVM)
    `CHK(srcs[8], SRC_FLASH)
    `CHK({done_o, global_output_enable_o, user_mode_o}, 3'h7)
    `CHK(bad_order, 1'b0)
    $display("Test JTAG wake after failure finished");
    end_of_test();
  end
endmodule : cbsw_core_bench

// ===== test/cbsw_loader_model.sv
// Far-side model: configuration image source and free-running link clock
// Assumes one-cycle load requests on the 100 MHz reference clock
`timescale 1ns/1ps
module cbsw_loader_model
  import cbsw_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_start_i,
  input  wire logic [1:0] load_source_i,
  input  wire logic       fail_flash_i,
  input  wire logic       fail_nvm_i,
  output logic            load_done_o,
  output logic            load_error_o,
  output logic            link_clk_o
);
  int unsigned cnt_q;
  logic        bad_q;
  // ----------------------------------------------------------------------
  // Link clock, 125 ns, runs freely so wake-up is never starved
  // ----------------------------------------------------------------------
  initial begin
    link_clk_o = 1'b0;
    forever #62.5 link_clk_o = ~link_clk_o;
  end
  // ----------------------------------------------------------------------
  // Image transfer: answers each request after 20 cycles
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q        <= 0;
      bad_q        <= 1'b0;
      load_done_o  <= 1'b0;
      load_error_o <= 1'b0;
    end else begin
      load_done_o  <= 1'b0;
      load_error_o <= 1'b0;
      if (load_start_i) begin
        cnt_q <= 20;
        bad_q <= (load_source_i == SRC_FLASH) ? fail_flash_i : fail_nvm_i;
      end else if (cnt_q == 1) begin
        cnt_q        <= 0;
        load_done_o  <= ~bad_q;
        load_error_o <= bad_q;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule : cbsw_loader_model
